// ---- design/dtm_timer.sv ----
// Dual counter/timer with shared mode register on an AXI4-Lite slave
// ======================================================
`timescale 1ns/1ps
`default_nettype none
module dtm_timer
    import dtm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ======================================================
    // State
    typedef struct packed {
        logic [2:0] pin_a;
        logic [2:0] pin_b;
        logic [2:0] irq_a;
        logic [2:0] irq_b;
        logic gate_a;
        logic gate_b;
        logic cnt_a;
        logic cnt_b;
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [7:0] irqcfg;
        logic [7:0] clkctl;
        logic [7:0] prescale;
        logic [7:0] a_low;
        logic [7:0] a_high;
        logic [7:0] b_low;
        logic [7:0] b_high;
        logic aw_have;
        logic [ADDR_W-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dtm_state_t;

    dtm_state_t s_q;
    dtm_state_t s_d;

    logic run_a;
    logic run_b;
    logic tick_pre;
    logic fall_a;
    logic fall_b;
    logic inc_a;
    logic inc_b;
    logic inc_a2;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic ovf_a;
    logic ovf_b;
    logic ovf_a2;
    logic [7:0] a_low_n;
    logic [7:0] a_high_n;
    logic [7:0] b_low_n;
    logic [7:0] b_high_n;
    logic wr_go;
    logic [7:0] wr_idx;
    logic [7:0] wbyte;
    logic [7:0] rd_idx;

    // Count step for one timer; shared by both halves of mode logic
    function automatic logic [16:0] dtm_step(
        input logic [1:0] mode,
        input logic [7:0] low,
        input logic [7:0] high
    );
        logic [16:0] r;
        r = {1'b0, high, low};
        unique case (mode)
            DTM_MODE_13: begin
                if (low[4:0] == DTM_LOW13_MAX) begin
                    r = {(high == 8'hff), high + 8'h01, 3'h0, 5'h00};
                end else begin
                    r = {1'b0, high, 3'h0, low[4:0] + 5'h01};
                end
            end
            DTM_MODE_16: begin
                r = {1'b0, high, low} + 17'h00001;
            end
            DTM_MODE_RELOAD: begin
                if (low == 8'hff) begin
                    r = {1'b1, high, high};
                end else begin
                    r = {1'b0, high, low + 8'h01};
                end
            end
            DTM_MODE_SPECIAL: begin
                r = {(low == 8'hff), high, low + 8'h01};
            end
        endcase
        return r;
    endfunction

    // ======================================================
    // Event detection and run qualification
    always_comb begin
        mode_a = s_q.mode[DTM_A_MODE_LSB +: 2];
        mode_b = s_q.mode[DTM_B_MODE_LSB +: 2];
        // Synchronisers: bits 2 and 1 agree before a change counts
        fall_a = (s_q.pin_a[2:1] == 2'b00) && s_q.cnt_a;
        fall_b = (s_q.pin_b[2:1] == 2'b00) && s_q.cnt_b;
        // Internal clock: prescaled tick or full system clock
        tick_pre = (s_q.prescale == 8'h00);
        // Polarity bit 1 means active high
        run_a = s_q.ctrl[DTM_A_RUN_BIT] && (!s_q.mode[DTM_A_GATE_BIT]
            || (s_q.gate_a == s_q.irqcfg[DTM_A_POL_BIT]));
        run_b = s_q.ctrl[DTM_B_RUN_BIT] && (!s_q.mode[DTM_B_GATE_BIT]
            || (s_q.gate_b == s_q.irqcfg[DTM_B_POL_BIT]));
        inc_a = run_a && (s_q.mode[DTM_A_SRC_BIT] ? fall_a
            : (s_q.clkctl[DTM_A_CLKSEL_BIT] || tick_pre));
        inc_b = run_b && (mode_b != DTM_MODE_SPECIAL)
            && (s_q.mode[DTM_B_SRC_BIT] ? fall_b
            : (s_q.clkctl[DTM_B_CLKSEL_BIT] || tick_pre));
        // Split mode: upper half borrows timer B's run bit, always timed
        inc_a2 = (mode_a == DTM_MODE_SPECIAL) && s_q.ctrl[DTM_B_RUN_BIT]
            && (s_q.clkctl[DTM_A_CLKSEL_BIT] || tick_pre);
        {ovf_a, a_high_n, a_low_n} = {1'b0, s_q.a_high, s_q.a_low};
        ovf_a2 = 1'b0;
        if (inc_a) begin
            {ovf_a, a_high_n, a_low_n} =
                dtm_step(mode_a, s_q.a_low, s_q.a_high);
            if (mode_a == DTM_MODE_SPECIAL) begin
                a_high_n = s_q.a_high;
            end
        end
        if (inc_a2) begin
            a_high_n = s_q.a_high + 8'h01;
            ovf_a2 = (s_q.a_high == 8'hff);
        end
        {ovf_b, b_high_n, b_low_n} = {1'b0, s_q.b_high, s_q.b_low};
        if (inc_b) begin
            {ovf_b, b_high_n, b_low_n} =
                dtm_step(mode_b, s_q.b_low, s_q.b_high);
        end
        wr_idx = s_q.aw_addr[9:2];
        rd_idx = s_axi_araddr[9:2];
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wbyte = s_q.w_strb[0] ? s_q.w_data[7:0] : 8'h00;
    end

    // ======================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.pin_a = {s_q.pin_a[1:0], timer_a_count_pin};
        s_d.pin_b = {s_q.pin_b[1:0], timer_b_count_pin};
        s_d.irq_a = {s_q.irq_a[1:0], ext_irq_a_pin};
        s_d.irq_b = {s_q.irq_b[1:0], ext_irq_b_pin};
        // Gate level moves only once flops two and three agree
        if (s_q.irq_a[2] == s_q.irq_a[1]) begin
            s_d.gate_a = s_q.irq_a[2];
        end
        if (s_q.irq_b[2] == s_q.irq_b[1]) begin
            s_d.gate_b = s_q.irq_b[2];
        end
        // Armed once a settled high is seen, so one fall counts once
        if (s_q.pin_a[2:1] == 2'b11) begin
            s_d.cnt_a = 1'b1;
        end else if (fall_a) begin
            s_d.cnt_a = 1'b0;
        end
        if (s_q.pin_b[2:1] == 2'b11) begin
            s_d.cnt_b = 1'b1;
        end else if (fall_b) begin
            s_d.cnt_b = 1'b0;
        end
        s_d.prescale = tick_pre
            ? s_q.clkctl[DTM_PRESCALE_LSB +: 2] * 8'h04 + 8'h03
            : s_q.prescale - 8'h01;
        s_d.a_low = a_low_n;
        s_d.a_high = a_high_n;
        s_d.b_low = b_low_n;
        s_d.b_high = b_high_n;
        // AXI write address and data may arrive in either order
        if (s_axi_awvalid && !s_q.aw_have) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_have) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = AXI_OKAY;
            if (s_q.w_strb[0]) begin
                unique case (wr_idx)
                    DTM_IDX_MODE: s_d.mode = wbyte;
                    DTM_IDX_A_HIGH: s_d.a_high = wbyte;
                    DTM_IDX_B_HIGH: s_d.b_high = wbyte;
                    DTM_IDX_A_LOW: s_d.a_low = wbyte;
                    DTM_IDX_B_LOW: s_d.b_low = wbyte;
                    DTM_IDX_IRQCFG: s_d.irqcfg = wbyte;
                    DTM_IDX_CLKCTL: s_d.clkctl = wbyte;
                    DTM_IDX_CTRL: begin
                        // Flags: write 0 clears, write 1 keeps
                        s_d.ctrl = wbyte & 8'h5e | (wbyte & s_q.ctrl & 8'ha1);
                    end
                    default: s_d.bresp = AXI_SLVERR;
                endcase
            end else if (!(wr_idx inside {DTM_IDX_MODE, DTM_IDX_A_HIGH,
                    DTM_IDX_B_HIGH, DTM_IDX_A_LOW, DTM_IDX_B_LOW,
                    DTM_IDX_IRQCFG, DTM_IDX_CLKCTL, DTM_IDX_CTRL})) begin
                s_d.bresp = AXI_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Hardware set wins over a same-cycle software clear
        if (ovf_a) begin
            s_d.ctrl[DTM_A_OVF_BIT] = 1'b1;
        end
        if (ovf_a2) begin
            s_d.ctrl[DTM_B_OVF_BIT] = 1'b1;
        end
        if (ovf_b) begin
            s_d.ctrl[DTM_B_OVF_BIT] = 1'b1;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = AXI_OKAY;
            s_d.rdata = 32'h00000000;
            unique case (rd_idx)
                DTM_IDX_MODE: s_d.rdata[7:0] = s_q.mode;
                DTM_IDX_A_HIGH: s_d.rdata[7:0] = s_q.a_high;
                DTM_IDX_B_HIGH: s_d.rdata[7:0] = s_q.b_high;
                DTM_IDX_A_LOW: s_d.rdata[7:0] = s_q.a_low;
                DTM_IDX_B_LOW: s_d.rdata[7:0] = s_q.b_low;
                DTM_IDX_IRQCFG: s_d.rdata[7:0] = s_q.irqcfg;
                DTM_IDX_CLKCTL: s_d.rdata[7:0] = s_q.clkctl;
                DTM_IDX_CTRL: s_d.rdata[7:0] = s_q.ctrl;
                default: s_d.rresp = AXI_SLVERR;
            endcase
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.mode <= DTM_RST_BYTE;
            s_q.a_high <= DTM_RST_BYTE;
            s_q.b_high <= DTM_RST_BYTE;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Bus outputs
    assign s_axi_awready = !s_q.aw_have;
    assign s_axi_wready = !s_q.w_have;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;

    // ======================================================
    // Assertions
    ungated_run_a: assert property (@(posedge clock) disable iff (rst)
        (!s_q.mode[DTM_A_GATE_BIT] && s_q.ctrl[DTM_A_RUN_BIT]) |-> run_a)
        else $error("ungated timer A not running");
    gated_stop_a: assert property (@(posedge clock) disable iff (rst)
        (s_q.mode[DTM_A_GATE_BIT]
        && s_q.gate_a != s_q.irqcfg[DTM_A_POL_BIT]) |-> !run_a)
        else $error("gated timer A ran with pin inactive");
    timed_count_a: assert property (@(posedge clock) disable iff (rst)
        (run_a && !s_q.mode[DTM_A_SRC_BIT] && s_q.clkctl[DTM_A_CLKSEL_BIT]
        && mode_a == DTM_MODE_16 && !wr_go)
        |=> {s_q.a_high, s_q.a_low} == $past({s_q.a_high, s_q.a_low}) + 16'h1)
        else $error("timer A missed internal tick");
    b_fall_count_a: assert property (@(posedge clock) disable iff (rst)
        (s_q.mode[DTM_B_SRC_BIT] && !fall_b) |-> !inc_b)
        else $error("timer B counted without a fall");
    a_fall_count_a: assert property (@(posedge clock) disable iff (rst)
        (run_a && s_q.mode[DTM_A_SRC_BIT] && fall_a) |-> inc_a)
        else $error("timer A missed a pin fall");
    b_inactive_a: assert property (@(posedge clock) disable iff (rst)
        (mode_b == DTM_MODE_SPECIAL && !wr_go)
        |=> $stable(s_q.b_low) && $stable(s_q.b_high))
        else $error("timer B counted in inactive mode");
    reload_low_a: assert property (@(posedge clock) disable iff (rst)
        (inc_a && mode_a == DTM_MODE_RELOAD && s_q.a_low == 8'hff && !wr_go)
        |=> s_q.a_low == $past(s_q.a_high) && $stable(s_q.a_high))
        else $error("auto-reload failed");
    ovf_flag_a: assert property (@(posedge clock) disable iff (rst)
        ovf_a |=> s_q.ctrl[DTM_A_OVF_BIT])
        else $error("overflow flag not set");
    mode13_wrap_a: assert property (@(posedge clock) disable iff (rst)
        (inc_a && mode_a == DTM_MODE_13 && s_q.a_low[4:0] == 5'h1f && !wr_go)
        |=> s_q.a_low == 8'h00)
        else $error("13-bit low part did not wrap at 32");
endmodule
`default_nettype wire

// ---- design/dtm_pkg.sv ----
// Package for the dual timer mode control block
package dtm_pkg;
    // ======================================================
    // Register indices (printed offsets are not word aligned)
    localparam logic [7:0] DTM_IDX_MODE = 8'h89;
    localparam logic [7:0] DTM_IDX_A_HIGH = 8'h8c;
    localparam logic [7:0] DTM_IDX_B_HIGH = 8'h8d;
    localparam logic [7:0] DTM_IDX_A_LOW = 8'h8a;
    localparam logic [7:0] DTM_IDX_B_LOW = 8'h8b;
    localparam logic [7:0] DTM_IDX_CTRL = 8'h88;
    localparam logic [7:0] DTM_IDX_IRQCFG = 8'he4;
    localparam logic [7:0] DTM_IDX_CLKCTL = 8'h8e;
    // ======================================================
    // Mode register fields
    localparam int DTM_B_GATE_BIT = 7;
    localparam int DTM_B_SRC_BIT = 6;
    localparam int DTM_B_MODE_LSB = 4;
    localparam int DTM_A_GATE_BIT = 3;
    localparam int DTM_A_SRC_BIT = 2;
    localparam int DTM_A_MODE_LSB = 0;
    // Control register fields (run bits and overflow flags)
    localparam int DTM_A_RUN_BIT = 4;
    localparam int DTM_A_OVF_BIT = 5;
    localparam int DTM_B_RUN_BIT = 6;
    localparam int DTM_B_OVF_BIT = 7;
    localparam int DTM_A2_OVF_BIT = 0;
    // Irq config polarity bits, clock control select bits
    localparam int DTM_A_POL_BIT = 3;
    localparam int DTM_B_POL_BIT = 7;
    localparam int DTM_A_CLKSEL_BIT = 2;
    localparam int DTM_B_CLKSEL_BIT = 3;
    localparam int DTM_PRESCALE_LSB = 0;
    // ======================================================
    // Reset values
    localparam logic [7:0] DTM_RST_BYTE = 8'h00;
    // ======================================================
    // Mode encodings
    localparam logic [1:0] DTM_MODE_13 = 2'h0;
    localparam logic [1:0] DTM_MODE_16 = 2'h1;
    localparam logic [1:0] DTM_MODE_RELOAD = 2'h2;
    localparam logic [1:0] DTM_MODE_SPECIAL = 2'h3;
    localparam logic [4:0] DTM_LOW13_MAX = 5'h1f;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ---- tb/dtm_pins.sv ----
// Pin-side model of the count and gate pins
`timescale 1ns/1ps
`default_nettype none
module dtm_pins (
    input wire logic clock,
    output logic timer_a_count_pin,
    output logic timer_b_count_pin,
    output logic ext_irq_a_pin,
    output logic ext_irq_b_pin
);
    initial begin
        timer_a_count_pin = 1'b1;
        timer_b_count_pin = 1'b1;
        ext_irq_a_pin = 1'b0;
        ext_irq_b_pin = 1'b0;
    end
    task automatic drive(input logic b, input logic lvl);
        if (b)
            timer_b_count_pin <= lvl;
        else
            timer_a_count_pin <= lvl;
    endtask
    // Each level held 4 cycles so the synchroniser sees a settled high
    task automatic falls(input logic b, input int n);
        repeat (n) begin
            drive(b, 1'b0);
            repeat (4) @(posedge clock);
            drive(b, 1'b1);
            repeat (4) @(posedge clock);
        end
    endtask
    task automatic gate(input logic a, input logic b);
        ext_irq_a_pin <= a;
        ext_irq_b_pin <= b;
    endtask
endmodule
`default_nettype wire

// ---- tb/dual_timer_mode_control_test.sv ----
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dual_timer_mode_control_test;
    import dtm_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    wire logic pa, pb, ia, ib;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v;
    int mismatches = 0;
    int n_checks = 0;
    always #12.5 clock = ~clock;
    dtm_pins dtm_pins_i (.clock(clock), .timer_a_count_pin(pa),
        .timer_b_count_pin(pb), .ext_irq_a_pin(ia), .ext_irq_b_pin(ib));
    dtm_timer dtm_timer_i (.clock(clock), .rst(rst),
        .timer_a_count_pin(pa), .timer_b_count_pin(pb),
        .ext_irq_a_pin(ia), .ext_irq_b_pin(ib),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    // ======================================================
    // Checking and bus tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Handshakes judged at the falling edge, acted on at the next rise
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er = AXI_OKAY);
        logic ta, tw, tb;
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clock);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                // One edge between calls so bready is not set twice
                @(posedge clock);
                return;
            end
        end
        mismatches++;
        close_out();
    endtask
    task automatic rd(input logic [7:0] idx, input logic [1:0] er = AXI_OKAY);
        logic ta, tr;
        logic [1:0] rr;
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge clock);
            ta = arvalid && arready;
            tr = rvalid;
            v = rdata;
            rr = rresp;
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0;
                chk("rresp", {30'h0, rr}, {30'h0, er});
                @(posedge clock);
                return;
            end
        end
        mismatches++;
        close_out();
    endtask
    task automatic rc(input logic [7:0] idx, input logic [7:0] e);
        rd(idx);
        chk($sformatf("reg %h", idx), v, {24'h0, e});
    endtask
    // ======================================================
    // Scenarios
    task automatic t_regs();
        rc(DTM_IDX_MODE, 8'h00);
        rc(DTM_IDX_A_HIGH, 8'h00);
        rc(DTM_IDX_B_HIGH, 8'h00);
        wr(DTM_IDX_A_HIGH, 8'h5a);
        wr(DTM_IDX_B_HIGH, 8'ha5);
        wr(DTM_IDX_MODE, 8'hc3);
        rc(DTM_IDX_A_HIGH, 8'h5a);
        rc(DTM_IDX_B_HIGH, 8'ha5);
        rc(DTM_IDX_MODE, 8'hc3);
        wr(8'h00, 8'h11, AXI_SLVERR);
        rd(8'h00, AXI_SLVERR);
        chk("unmapped", v, 32'h0);
    endtask
    // Run a few counts past a wrap, then stop keeping the flags
    task automatic ovf(input logic [7:0] md, lo, hi, eh,
                       input logic [2:0] el);
        wr(DTM_IDX_MODE, md);
        wr(DTM_IDX_A_LOW, lo);
        wr(DTM_IDX_A_HIGH, hi);
        wr(DTM_IDX_CTRL, 8'h10);
        repeat (6) @(posedge clock);
        wr(DTM_IDX_CTRL, 8'ha0);
        rc(DTM_IDX_A_HIGH, eh);
        rd(DTM_IDX_A_LOW);
        chk("low top", {29'h0, v[7:5]}, {29'h0, el});
        rc(DTM_IDX_CTRL, 8'h20);
        wr(DTM_IDX_CTRL, 8'h00);
        rc(DTM_IDX_CTRL, 8'h00);
    endtask
    task automatic t_pins();
        wr(DTM_IDX_MODE, 8'h55);
        wr(DTM_IDX_A_LOW, 8'h00);
        wr(DTM_IDX_B_LOW, 8'h00);
        wr(DTM_IDX_CTRL, 8'h50);
        dtm_pins_i.falls(1'b0, 3);
        dtm_pins_i.falls(1'b1, 2);
        rc(DTM_IDX_A_LOW, 8'h03);
        rc(DTM_IDX_B_LOW, 8'h02);
        wr(DTM_IDX_MODE, 8'h75);
        dtm_pins_i.falls(1'b1, 2);
        rc(DTM_IDX_B_LOW, 8'h02);
    endtask
    task automatic t_gate();
        wr(DTM_IDX_CTRL, 8'h00);
        wr(DTM_IDX_IRQCFG, 8'h88);
        wr(DTM_IDX_MODE, 8'h0d);
        wr(DTM_IDX_A_LOW, 8'h00);
        wr(DTM_IDX_CTRL, 8'h10);
        dtm_pins_i.falls(1'b0, 2);
        rc(DTM_IDX_A_LOW, 8'h00);
        dtm_pins_i.gate(1'b1, 1'b0);
        repeat (4) @(posedge clock);
        dtm_pins_i.falls(1'b0, 2);
        rc(DTM_IDX_A_LOW, 8'h02);
        // Polarity flipped: a high pin now holds the timer
        wr(DTM_IDX_IRQCFG, 8'h00);
        dtm_pins_i.falls(1'b0, 1);
        rc(DTM_IDX_A_LOW, 8'h02);
        wr(DTM_IDX_MODE, 8'h05);
        dtm_pins_i.falls(1'b0, 1);
        rc(DTM_IDX_A_LOW, 8'h03);
    endtask
    task automatic t_split();
        wr(DTM_IDX_CTRL, 8'h00);
        wr(DTM_IDX_MODE, 8'h07);
        wr(DTM_IDX_A_LOW, 8'h00);
        wr(DTM_IDX_A_HIGH, 8'h00);
        wr(DTM_IDX_CTRL, 8'h10);
        dtm_pins_i.falls(1'b0, 2);
        rc(DTM_IDX_A_HIGH, 8'h00);
        wr(DTM_IDX_CTRL, 8'h50);
        dtm_pins_i.falls(1'b0, 1);
        wr(DTM_IDX_CTRL, 8'ha0);
        rc(DTM_IDX_A_LOW, 8'h03);
        rd(DTM_IDX_A_HIGH);
        chk("split high", {31'h0, v[7:0] != 8'h00}, 32'h1);
    endtask
    // Prescaled tick: one count per 16 cycles, phase unknown
    task automatic t_tick();
        wr(DTM_IDX_CTRL, 8'h00);
        wr(DTM_IDX_MODE, 8'h10);
        wr(DTM_IDX_CLKCTL, 8'h07);
        wr(DTM_IDX_B_LOW, 8'h00);
        wr(DTM_IDX_CTRL, 8'h40);
        repeat (64) @(posedge clock);
        wr(DTM_IDX_CTRL, 8'h00);
        rd(DTM_IDX_B_LOW);
        chk("tick", {31'h0, v[7:0] inside {8'h04, 8'h05}}, 32'h1);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_regs();
        wr(DTM_IDX_CLKCTL, 8'h0c);
        ovf(8'h01, 8'hfe, 8'hff, 8'h00, 3'h0);
        ovf(8'h00, 8'h1f, 8'hff, 8'h00, 3'h0);
        ovf(8'h02, 8'hff, 8'h80, 8'h80, 3'h4);
        t_pins();
        t_gate();
        t_split();
        t_tick();
        close_out();
    end
endmodule
`default_nettype wire
